//--- bench/fbled_led_model.sv
// fbled_led_model: behavioural indicator LED seen from the far side of one pin
// assumes the pin is sampled on clk; high means the LED is lit
`timescale 1ns/10ps

module fbled_led_model (
    input  wire logic clk,
    input  wire logic led,
    output int        on_len,
    output int        off_len,
    output int        prev_off
);
    int   run = 0;
    logic last = 1'h0;

    // lengths of the last finished lit run and the last two dark runs, in clocks
    initial begin
        on_len = 0;
        off_len = 0;
        prev_off = 0;
    end

    always @(posedge clk) begin
        if (led === last) begin
            run <= run + 1;
        end else begin
            if (last) begin
                on_len <= run;
            end else begin
                off_len <= run;
                prev_off <= off_len;
            end
            run <= 1;
            last <= led;
        end
    end
endmodule : fbled_led_model

//--- bench/tb_top.sv
// tb_top: self-checking bench of the indicator block
// assumes fbled_pkg is compiled first; one ms is shortened to 4 clocks
`timescale 1ns/10ps

module tb_top;
    import fbled_pkg::*;
    localparam int M = 4;
    logic            clk = 1'h0;
    logic            resetn = 1'h0;
    fbled_link_type  link_in = '0;
    fbled_link_type  link_out = '0;
    fbled_state_type state_in = '0;
    fbled_error_type error_in = '0;
    logic            bicolor_mode = 1'h0;
    logic            input_port_link_led, output_port_link_led;
    logic            status_err_pos, status_err_neg;
    int              on_p, off_p, pr_p, on_n, off_n, pr_n, on_i, off_i, pr_i, on_o, off_o, pr_o;
    int              n_fail = 0;
    int              total_checks = 0;

    always #25 clk = ~clk;

    fbled_indicators #(.CYCLES_PER_MS(15'h0004)) DUT (
        .clk(clk), .resetn(resetn), .link_in(link_in), .link_out(link_out),
        .state_in(state_in), .error_in(error_in), .bicolor_mode(bicolor_mode),
        .input_port_link_led(input_port_link_led), .output_port_link_led(output_port_link_led),
        .status_err_pos(status_err_pos), .status_err_neg(status_err_neg));
    fbled_led_model m_pos (.clk(clk), .led(status_err_pos), .on_len(on_p), .off_len(off_p),
        .prev_off(pr_p));
    fbled_led_model m_neg (.clk(clk), .led(status_err_neg), .on_len(on_n), .off_len(off_n),
        .prev_off(pr_n));
    fbled_led_model m_lin (.clk(clk), .led(input_port_link_led), .on_len(on_i),
        .off_len(off_i), .prev_off(pr_i));
    fbled_led_model m_lout (.clk(clk), .led(output_port_link_led), .on_len(on_o),
        .off_len(off_o), .prev_off(pr_o));

    // ****************
    // helpers
    // ****************
    task automatic chk_lvl(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_lvl

    task automatic chk_cnt(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_cnt

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step

    // flags: booting, fw_download, pdi_wd, config_err, app_wd
    task automatic drive(input fbled_al_type al, input logic [7:0] chg, input logic [4:0] f);
        @(posedge clk);
        state_in <= '{al, chg, f[4], f[3]};
        error_in <= '{f[2], f[1], f[0]};
    endtask : drive

    task automatic hold(input string what, input logic exp, ref logic pin);
        repeat (40) begin
            repeat (50) @(negedge clk);
            chk_lvl(what, exp, pin);
        end
    endtask : hold

    // waits two whole periods, then judges the finished run lengths
    task automatic pat(input string what, input bit red, input int on, input int off,
                       input bit dbl, input int n);
        step(n);
        chk_cnt({what, " lit"}, on * M, red ? on_n : on_p);
        if (dbl) begin
            chk_cnt({what, " dark"}, off * M, off_n + pr_n);
        end else begin
            chk_cnt({what, " dark"}, off * M, red ? off_n : off_p);
        end
    endtask : pat

    // ****************
    // scenarios
    // ****************
    task automatic t_link;
        @(posedge clk);
        link_in <= '{1'h0, 1'h1};
        link_out <= '{1'h1, 1'h0};
        step(3);
        @(negedge clk);
        chk_lvl("in link invalid", 1'h0, input_port_link_led);
        chk_lvl("out link idle", 1'h1, output_port_link_led);
        @(posedge clk);
        link_in <= '{1'h1, 1'h1};
        link_out <= '{1'h1, 1'h1};
        step(1000);
        chk_cnt("in link lit", 50 * M, on_i);
        chk_cnt("in link dark", 50 * M, off_i);
        chk_cnt("out link lit", 50 * M, on_o);
        chk_cnt("out link dark", 50 * M, off_o);
        @(posedge clk);
        link_in <= '{1'h1, 1'h0};
        link_out <= '0;
        step(500);
        hold("in link idle", 1'h1, input_port_link_led);
        chk_lvl("out link dropped", 1'h0, output_port_link_led);
        $display("test link done");
    endtask : t_link

    task automatic t_status;
        drive(AL_OP, 8'h00, 5'h00);
        hold("status op", 1'h1, status_err_pos);
        drive(AL_INIT, 8'h00, 5'h00);
        hold("status init", 1'h0, status_err_pos);
        drive(AL_BOOT, 8'h00, 5'h00);
        pat("status bootstrap", 1'h0, 50, 50, 1'h0, 900);
        drive(AL_PREOP, 8'h00, 5'h00);
        pat("status preop", 1'h0, 200, 200, 1'h0, 3300);
        drive(AL_PREOP, 8'h00, 5'h08);
        pat("status download", 1'h0, 50, 50, 1'h0, 900);
        drive(AL_SAFEOP, 8'h00, 5'h00);
        pat("status safeop", 1'h0, 200, 1000, 1'h0, 9700);
        drive(AL_SAFEOP, 8'h00, 5'h10);
        pat("status booting", 1'h0, 50, 50, 1'h0, 900);
        $display("test status done");
    endtask : t_status

    task automatic t_error;
        drive(AL_OP, 8'h00, 5'h04);
        hold("error pdi", 1'h1, status_err_neg);
        drive(AL_OP, 8'h00, 5'h02);
        pat("error config", 1'h1, 200, 200, 1'h0, 3300);
        drive(AL_INIT, CHANGE_ERR, 5'h00);
        pat("error boot", 1'h1, 50, 50, 1'h0, 900);
        chk_lvl("status init boot error", 1'h0, status_err_pos);
        drive(AL_SAFEOP, CHANGE_ERR, 5'h00);
        pat("error autonomous", 1'h1, 200, 1000, 1'h0, 9700);
        drive(AL_OP, 8'h00, 5'h01);
        pat("error app wd", 1'h1, 200, 1200, 1'h1, 13000);
        drive(AL_OP, 8'h00, 5'h05);
        hold("error pdi over app", 1'h1, status_err_neg);
        $display("test error done");
    endtask : t_error

    task automatic t_restart;
        int n;
        n = 0;
        drive(AL_PREOP, 8'h00, 5'h00);
        step(810);
        @(negedge clk);
        while (status_err_pos !== 1'h0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            n_fail++;
            $display("ERROR restart wait expected dark seen lit");
            conclude();
        end
        drive(AL_SAFEOP, 8'h00, 5'h00);
        step(2);
        @(negedge clk);
        chk_lvl("restart lit", 1'h1, status_err_pos);
        $display("test restart done");
    endtask : t_restart

    task automatic t_bicolor;
        @(posedge clk);
        bicolor_mode <= 1'h1;
        drive(AL_OP, 8'h00, 5'h04);
        step(4);
        @(negedge clk);
        chk_lvl("bicolor green", 1'h0, status_err_pos);
        chk_lvl("bicolor red", 1'h1, status_err_neg);
        drive(AL_OP, 8'h00, 5'h00);
        step(4);
        @(negedge clk);
        chk_lvl("bicolor green only", 1'h1, status_err_pos);
        chk_lvl("bicolor red off", 1'h0, status_err_neg);
        @(posedge clk);
        bicolor_mode <= 1'h0;
        drive(AL_OP, 8'h00, 5'h04);
        step(4);
        @(negedge clk);
        chk_lvl("two led green", 1'h1, status_err_pos);
        chk_lvl("two led red", 1'h1, status_err_neg);
        $display("test bicolor done");
    endtask : t_bicolor

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    initial begin
        step(3);
        @(negedge clk);
        chk_lvl("reset status", 1'h0, status_err_pos);
        chk_lvl("reset error", 1'h0, status_err_neg);
        chk_lvl("reset in link", 1'h0, input_port_link_led);
        chk_lvl("reset out link", 1'h0, output_port_link_led);
        @(posedge clk);
        resetn <= 1'h1;
        t_link();
        t_status();
        t_error();
        t_restart();
        t_bicolor();
        conclude();
    end

    initial begin
        #4750000;
        n_fail++;
        $display("ERROR run limit expected done seen running");
        conclude();
    end
endmodule : tb_top

//--- design/fbled_indicators.sv
// fbled_indicators: network link/activity, status and error LED driver
// assumes all inputs come from logic on clk; LEDs lit on high output
`timescale 1ns/10ps

module fbled_indicators #(
    parameter logic [14:0] CYCLES_PER_MS = fbled_pkg::MS_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire fbled_pkg::fbled_link_type   link_in,
    input  wire fbled_pkg::fbled_link_type   link_out,
    input  wire fbled_pkg::fbled_state_type  state_in,
    input  wire fbled_pkg::fbled_error_type  error_in,
    input  wire logic                        bicolor_mode,
    output logic                             input_port_link_led,
    output logic                             output_port_link_led,
    output logic                             status_err_pos,
    output logic                             status_err_neg
);
    import fbled_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ****************
    // millisecond timebase
    // ****************
    logic [14:0] ms_cnt;
    logic [14:0] next_ms_cnt;
    logic        ms_tick;

    assign ms_tick = (ms_cnt == CYCLES_PER_MS - 15'h0001);

    always_comb begin
        next_ms_cnt = ms_tick ? 15'h0000 : ms_cnt + 15'h0001;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_cnt <= 15'h0000;
        end else begin
            ms_cnt <= next_ms_cnt;
        end
    end

    // ****************
    // indication select
    // ****************
    fbled_pat_type want [2];
    logic          boot_err;
    logic          auto_change;

    assign boot_err    = (state_in.al_state == AL_INIT) &&
                         (state_in.change_ind == CHANGE_ERR);
    assign auto_change = (state_in.al_state != AL_INIT) &&
                         (state_in.change_ind == CHANGE_ERR);

    always_comb begin
        if (state_in.booting || state_in.fw_download) begin
            want[0] = PAT_FLICKER;
        end else begin
            case (state_in.al_state)
                AL_OP:     want[0] = PAT_ON;
                AL_PREOP:  want[0] = PAT_BLINK;
                AL_SAFEOP: want[0] = PAT_SINGLE;
                AL_BOOT:   want[0] = PAT_FLICKER;
                AL_INIT:   want[0] = PAT_OFF;
                default:   want[0] = PAT_OFF;
            endcase
        end
    end

    // error priority: hard watchdog first, configuration error last
    always_comb begin
        if (error_in.pdi_wd) begin
            want[1] = PAT_ON;
        end else if (boot_err) begin
            want[1] = PAT_FLICKER;
        end else if (error_in.app_wd) begin
            want[1] = PAT_DOUBLE;
        end else if (auto_change) begin
            want[1] = PAT_SINGLE;
        end else if (error_in.config_err) begin
            want[1] = PAT_BLINK;
        end else begin
            want[1] = PAT_OFF;
        end
    end

    // ****************
    // pattern position, one per LED channel
    // ****************
    fbled_pat_type sel_q      [2];
    fbled_pat_type next_sel   [2];
    logic [10:0]   pos_q      [2];
    logic [10:0]   next_pos   [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_sel[i] = want[i];
            if (want[i] != sel_q[i]) begin
                next_pos[i] = POS_RESET;
            end else if (ms_tick) begin
                if (pos_q[i] == pat_period(sel_q[i]) - 11'h001) begin
                    next_pos[i] = POS_RESET;
                end else begin
                    next_pos[i] = pos_q[i] + 11'h001;
                end
            end else begin
                next_pos[i] = pos_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 2; i++) begin
                sel_q[i] <= PAT_OFF;
                pos_q[i] <= POS_RESET;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                sel_q[i] <= next_sel[i];
                pos_q[i] <= next_pos[i];
            end
        end
    end

    property p_single_period;
        sel_q[0] == PAT_SINGLE |-> pos_q[0] < PER_SGL;
    endproperty
    a_single_period: assert property (p_single_period) else $error("flash period");

    property p_flick_period;
        sel_q[1] == PAT_FLICKER |-> pos_q[1] < PER_FLICK;
    endproperty
    a_flick_period: assert property (p_flick_period) else $error("flicker period");

    property p_restart;
        !$stable(sel_q[0]) |-> pos_q[0] == POS_RESET;
    endproperty
    a_restart: assert property (p_restart) else $error("pattern not restarted");

    property p_config_blink;
        error_in.config_err && !error_in.pdi_wd && !error_in.app_wd &&
        state_in.change_ind != CHANGE_ERR |=> sel_q[1] == PAT_BLINK;
    endproperty
    a_config_blink: assert property (p_config_blink) else $error("config not blinking");

    // ****************
    // status/error pin pair
    // ****************
    logic green_lit;
    logic red_lit;
    logic next_pin_pos;
    logic next_pin_neg;

    assign green_lit = pat_lit(sel_q[0], pos_q[0]);
    assign red_lit   = pat_lit(sel_q[1], pos_q[1]);

    // bi-color LED cannot show both: red wins there
    always_comb begin
        next_pin_pos = green_lit && !(bicolor_mode && red_lit);
        next_pin_neg = red_lit;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_err_pos <= 1'h0;
            status_err_neg <= 1'h0;
        end else begin
            status_err_pos <= next_pin_pos;
            status_err_neg <= next_pin_neg;
        end
    end

    sequence s_op_steady;
        (state_in.al_state == AL_OP && !state_in.booting && !state_in.fw_download &&
         !bicolor_mode)[*3];
    endsequence

    sequence s_init_steady;
        (state_in.al_state == AL_INIT && !state_in.booting && !state_in.fw_download)[*3];
    endsequence

    property p_op_on;
        s_op_steady |-> status_err_pos;
    endproperty
    a_op_on: assert property (p_op_on) else $error("status dark in OP");

    property p_init_off;
        s_init_steady |-> !status_err_pos;
    endproperty
    a_init_off: assert property (p_init_off) else $error("status lit in INIT");

    property p_blink_dark;
        sel_q[0] == PAT_BLINK && pos_q[0] >= FLASH_MS |=> !status_err_pos;
    endproperty
    a_blink_dark: assert property (p_blink_dark) else $error("blink dark phase lit");

    property p_flick_dark;
        sel_q[0] == PAT_FLICKER && pos_q[0] >= FLICK_MS |=> !status_err_pos;
    endproperty
    a_flick_dark: assert property (p_flick_dark) else $error("flicker dark lit");

    property p_pdi_on;
        error_in.pdi_wd [*3] |-> status_err_neg;
    endproperty
    a_pdi_on: assert property (p_pdi_on) else $error("red dark on watchdog");

    property p_single_dark;
        sel_q[1] == PAT_SINGLE && pos_q[1] >= FLASH_MS |=> !status_err_neg;
    endproperty
    a_single_dark: assert property (p_single_dark) else $error("single dark lit");

    property p_double_second;
        sel_q[1] == PAT_DOUBLE && pos_q[1] >= PER_BLINK &&
        pos_q[1] < PER_BLINK + FLASH_MS |=> status_err_neg;
    endproperty
    a_double_second: assert property (p_double_second) else $error("second flash");

    property p_bicolor;
        $past(bicolor_mode) && status_err_neg |-> !status_err_pos;
    endproperty
    a_bicolor: assert property (p_bicolor) else $error("both colours driven");

    // ****************
    // link/activity LEDs
    // ****************
    logic [6:0] flick_ms;
    logic [6:0] next_flick_ms;
    logic       flick_wrap;
    logic       flick_phase;
    logic [1:0] act_hold;
    logic [1:0] next_act_hold;
    logic [1:0] link_valid;
    logic [1:0] link_act;
    logic [1:0] next_link_led;

    assign link_valid  = {link_out.valid, link_in.valid};
    assign link_act    = {link_out.activity, link_in.activity};
    assign flick_wrap  = ms_tick && (flick_ms == LINK_PER - 7'h01);
    assign flick_phase = (flick_ms >= LINK_HALF);

    always_comb begin
        if (flick_wrap) begin
            next_flick_ms = 7'h00;
        end else if (ms_tick) begin
            next_flick_ms = flick_ms + 7'h01;
        end else begin
            next_flick_ms = flick_ms;
        end
        for (int i = 0; i < 2; i++) begin
            // new traffic wins over the end-of-period clear
            next_act_hold[i] = link_act[i] || (act_hold[i] && !flick_wrap);
            next_link_led[i] = link_valid[i] && !(act_hold[i] && flick_phase);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flick_ms             <= 7'h00;
            act_hold             <= 2'h0;
            input_port_link_led  <= 1'b0;
            output_port_link_led <= 1'b0;
        end else begin
            flick_ms             <= next_flick_ms;
            act_hold             <= next_act_hold;
            input_port_link_led  <= next_link_led[0];
            output_port_link_led <= next_link_led[1];
        end
    end

    sequence s_traffic;
        (link_out.valid && link_out.activity) ##1 (link_out.valid && flick_phase);
    endsequence

    property p_link_steady;
        link_in.valid && !link_in.activity && !act_hold[0] |=> input_port_link_led;
    endproperty
    a_link_steady: assert property (p_link_steady) else $error("idle link LED not lit");

    property p_link_dark;
        !link_in.valid |=> !input_port_link_led;
    endproperty
    a_link_dark: assert property (p_link_dark) else $error("invalid link LED lit");

    property p_link_flicker;
        s_traffic |=> !output_port_link_led;
    endproperty
    a_link_flicker: assert property (p_link_flicker) else $error("no flicker");

endmodule : fbled_indicators

//--- include/fbled_pkg.sv
// fbled_pkg: types, constants and pattern functions of the indicator block
// assumes a 20 MHz system clock and a millisecond timebase derived from it
package fbled_pkg;

    // ****************
    // timing
    // ****************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_TIME_NS    = 1_000_000;
    localparam int MS_CYCLES_INT = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [14:0] MS_CYCLES = 15'(MS_CYCLES_INT);

    localparam logic [10:0] FLASH_MS  = 11'h0C8;
    localparam logic [10:0] PAUSE_MS  = 11'h3E8;
    localparam logic [10:0] FLICK_MS  = 11'h032;
    localparam logic [10:0] PER_ONE   = 11'h001;
    localparam logic [10:0] PER_BLINK = 11'(2 * FLASH_MS);
    localparam logic [10:0] PER_SGL   = 11'(FLASH_MS + PAUSE_MS);
    localparam logic [10:0] PER_DBL   = 11'(3 * FLASH_MS + PAUSE_MS);
    localparam logic [10:0] PER_FLICK = 11'(2 * FLICK_MS);
    localparam logic [6:0]  LINK_HALF = 7'h32;
    localparam logic [6:0]  LINK_PER  = 7'h64;
    localparam logic [7:0]  CHANGE_ERR = 8'h01;
    localparam logic [10:0] POS_RESET = 11'h000;

    // ****************
    // types
    // ****************
    typedef enum logic [2:0] {
        AL_INIT, AL_PREOP, AL_SAFEOP, AL_OP, AL_BOOT
    } fbled_al_type;

    typedef enum logic [2:0] {
        PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE, PAT_FLICKER
    } fbled_pat_type;

    typedef struct packed {
        logic valid;
        logic activity;
    } fbled_link_type;

    typedef struct packed {
        fbled_al_type al_state;
        logic [7:0]   change_ind;
        logic         booting;
        logic         fw_download;
    } fbled_state_type;

    typedef struct packed {
        logic pdi_wd;
        logic config_err;
        logic app_wd;
    } fbled_error_type;

    function automatic logic [10:0] pat_period(fbled_pat_type p);
        case (p)
            PAT_BLINK:   return PER_BLINK;
            PAT_SINGLE:  return PER_SGL;
            PAT_DOUBLE:  return PER_DBL;
            PAT_FLICKER: return PER_FLICK;
            default:     return PER_ONE;
        endcase
    endfunction : pat_period

    function automatic logic pat_lit(fbled_pat_type p, logic [10:0] pos);
        case (p)
            PAT_ON:      return 1'h1;
            PAT_BLINK:   return pos < FLASH_MS;
            PAT_SINGLE:  return pos < FLASH_MS;
            PAT_DOUBLE:  return (pos < FLASH_MS) ||
                                (pos >= 11'(2 * FLASH_MS) && pos < 11'(3 * FLASH_MS));
            PAT_FLICKER: return pos < FLICK_MS;
            default:     return 1'h0;
        endcase
    endfunction : pat_lit

endpackage : fbled_pkg
